/* mms_defs.svh */
// Constants for the module management status and timing block
`ifndef MMS_DEFS_SVH
`define MMS_DEFS_SVH

// Clock rate of clk_sys
`define MMS_CLK_HZ         100000000
`define MMS_CYC_PER_MS     (`MMS_CLK_HZ / 1000)
`define MMS_CYC_PER_US     (`MMS_CLK_HZ / 1000000)

// Management init interval, longest time, in ms
`define MMS_INIT_MS        2000
`define MMS_INIT_CYC       (`MMS_INIT_MS * `MMS_CYC_PER_MS)

// Least reset pulse on the reset pin, in us
`define MMS_RST_MIN_US     10
`define MMS_RST_MIN_CYC    (`MMS_RST_MIN_US * `MMS_CYC_PER_US)

// Fast mode caps on advertised turn-off / turn-on limits, in ms
`define MMS_FAST_OFF_MS    3
`define MMS_FAST_ON_MS     10

// Register byte addresses
`define MMS_AW             5
`define MMS_REG_CTRL       5'h00
`define MMS_REG_FLAGS      5'h04
`define MMS_REG_MASK       5'h08
`define MMS_REG_STATUS     5'h0c
`define MMS_REG_ADV        5'h10

// Control register fields
`define MMS_CTRL_W         5
`define MMS_CTRL_RST       5'h00
`define MMS_CTRL_TXDIS     0
`define MMS_CTRL_RXDIS     1
`define MMS_CTRL_FAST      2
`define MMS_CTRL_SQDIS     3
`define MMS_CTRL_INTSEL    4

// Flag register fields
`define MMS_FLAG_LOS       0
`define MMS_FLAG_TXF       1
`define MMS_FLAG_OTHER     2

// Status register fields
`define MMS_ST_READY       0
`define MMS_ST_HOST        1
`define MMS_ST_RXSQ        2
`define MMS_ST_TXSQ        3
`define MMS_ST_RSTHOLD     4
`define MMS_ST_LOS         5
`define MMS_ST_TXF         6
`define MMS_ST_W           7

// Advertised limit register fields
`define MMS_ADV_OFF_LSB    0
`define MMS_ADV_ON_LSB     8

`endif

/* mms_host_model.sv */
// Host side model: two-wire frames and reset pin pulses
`timescale 1ns/1ps

module mms_host_model (
  // Clock
  input  wire logic clk_sys,
  // Two-wire bus, pulled up while idle
  output logic      scl,
  output logic      sda,
  // Reset pin
  output logic      reset_input_low
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    reset_input_low = 1'b1;
  end

  // Start, eight bit clocks at 80 ns, stop; clock stands high between frames
  task automatic frame(input logic [7:0] b);
    #3;
    sda = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--)
    begin
      scl = 1'b0;
      #20;
      sda = b[i];
      #20;
      scl = 1'b1;
      #40;
    end
    scl = 1'b0;
    #20;
    sda = 1'b0;
    #20;
    scl = 1'b1;
    #20;
    sda = 1'b1;
  endtask

  // Pin held low n cycles; n of 1000 or more asks for a module reset
  task automatic reset_pulse(input int n);
    @(posedge clk_sys);
    reset_input_low <= 1'b0;
    repeat (n) @(posedge clk_sys);
    reset_input_low <= 1'b1;
  endtask
endmodule

/* mms_monitor.sv */
// Concurrent checks on the management status block's ports
`timescale 1ns/1ps
`include "mms_defs.svh"

module mms_monitor #(
  parameter int          N_OTHER  = 2,
  parameter int unsigned INIT_CYC = 50
) (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               nrst,
  // Register bus
  input wire logic [`MMS_AW-1:0] avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic               avs_waitrequest,
  // Pins and conditions
  input wire logic               reset_input_low,
  input wire logic               rx_los_in,
  input wire logic               tx_fault_in,
  input wire logic               tx_sig_lost_in,
  input wire logic [N_OTHER-1:0] other_cond_in,
  // Outputs
  input wire logic               interrupt_out_low,
  input wire logic               mgmt_ready,
  input wire logic               module_reset,
  input wire logic               rx_out_enable,
  input wire logic               tx_out_enable
);
  logic [10:0] low_q;
  logic [10:0] low_d;
  logic [31:0] wait_q;
  logic [31:0] wait_d;
  wire         wr_ok   = avs_write & ~avs_waitrequest;
  wire         ctrl_wr = wr_ok & (avs_address == `MMS_REG_CTRL);
  wire         mask_wr = wr_ok & (avs_address == `MMS_REG_MASK);
  wire         flag_rd = avs_read & ~avs_waitrequest & (avs_address == `MMS_REG_FLAGS);
  // Saturates so a long hold cannot wrap back under the limit
  assign low_d  = reset_input_low ? 11'h000 : low_q + 11'(low_q != 11'h7ff);
  assign wait_d = (mgmt_ready | module_reset) ? 32'h0 : wait_q + 32'h1;
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      low_q  <= 11'h000;
      wait_q <= 32'h0;
    end
    else
    begin
      low_q  <= low_d;
      wait_q <= wait_d;
    end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  init_bound_a: assert property (wait_q <= INIT_CYC + 8)
    else $error("management not ready in time");
  rst_qual_a: assert property ($rose(module_reset) |-> low_q >= 11'h3e8)
    else $error("module reset on a short pulse");
  rst_take_a: assert property (low_q == 11'h3f0 |-> module_reset)
    else $error("long reset pulse not taken");
  rx_squelch_a: assert property ($rose(rx_los_in) |-> ##[1:4] !rx_out_enable)
    else $error("receive not squelched");
  tx_squelch_a: assert property ($rose(tx_sig_lost_in) |-> ##[1:4] !tx_out_enable)
    else $error("transmit not squelched");
  tx_off_a: assert property (ctrl_wr && avs_writedata[0] |-> ##[1:2] !tx_out_enable)
    else $error("transmit disable late");
  rx_off_a: assert property (ctrl_wr && avs_writedata[1] |-> ##[1:2] !rx_out_enable)
    else $error("receive disable late");
  tx_on_a: assert property ((!tx_sig_lost_in && !module_reset)[*4] ##0
    (ctrl_wr && !avs_writedata[0]) |-> ##[1:2] tx_out_enable)
    else $error("transmit enable late");
  mask_all_a: assert property (mask_wr && &avs_writedata[N_OTHER+1:0]
    |-> ##[1:2] interrupt_out_low)
    else $error("interrupt not masked");
  clear_rel_a: assert property ($stable({rx_los_in, tx_fault_in, other_cond_in})[*6] ##0
    flag_rd |-> ##[1:2] interrupt_out_low)
    else $error("interrupt not released after clear");

  cover property ($fell(interrupt_out_low));
  cover property ($rose(module_reset));
  cover property ($rose(mgmt_ready));
endmodule

/* mms_pkg.sv */
// Types shared by the module management status and timing block
package mms_pkg;

  typedef enum logic [1:0]
  {
    MMS_INIT_WAIT,
    MMS_INIT_HOLD,
    MMS_INIT_READY
  } mms_init_t;

endpackage

/* mms_sync.sv */
// Two-flop synchroniser for a vector of pins
`timescale 1ns/1ps

module mms_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* mms_top.sv */
// Management status, interrupt, squelch and disable timing logic
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "mms_defs.svh"

// What this block does
// - Management becomes ready to acknowledge within 2000 ms after power, plug or reset.
// - A reset pin low for at least 10 us is taken as a module reset.
// - Interrupt pin goes low within 200 ms of a triggering condition.
// - Interrupt releases within 500 us of the read that clears its flag.
// - Loss of signal sets its flag and the interrupt within 100 ms.
// - Transmit fault sets its flag and the interrupt within 200 ms.
// - Any other condition sets its flag and the interrupt within 200 ms.
// - Setting a mask bit stops that flag's interrupt within 100 ms.
// - Clearing a mask bit resumes that flag's interrupt within 100 ms.
// - Receive output is squelched within 15 ms of losing optical input.
// - Transmit output is squelched within 400 ms of losing electrical input.
// - Transmit squelch releases within 5 s after input returns.
// - Transmit disable brings the optical output down within 100 ms.
// - In fast mode transmit disable takes effect within 3 ms.
// - Clearing transmit disable restores optical output within 400 ms.
// - In fast mode clearing transmit disable restores output within 10 ms.
// - Receive output disable removes receive output within 100 ms.
// - Clearing receive output disable restores receive output within 100 ms.
// - Automatic squelch cannot be disabled; the squelch-disable control does nothing.
// - Advertised turn-off and turn-on limits never exceed the fast mode limits.
// - Interrupt pin may instead carry the second channel transmit fault.
module mms_top #(
  parameter int          N_OTHER     = 2,
  parameter int unsigned INIT_CYC    = `MMS_INIT_CYC,
  parameter logic [7:0]  ADV_OFF_MS  = 8'h03,
  parameter logic [7:0]  ADV_ON_MS   = 8'h0a
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  // Avalon-MM register slave
  input  wire logic [`MMS_AW-1:0]   avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // Module pins and monitored conditions
  input  wire logic                 reset_input_low,
  input  wire logic                 rx_los_in,
  input  wire logic                 tx_fault_in,
  input  wire logic                 tx_sig_lost_in,
  input  wire logic [N_OTHER-1:0]   other_cond_in,
  input  wire logic                 second_channel_tx_fault,
  // Two-wire management bus, observed only
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  // Outputs
  output logic                      interrupt_out_low,
  output logic                      mgmt_ready,
  output logic                      module_reset,
  output logic                      rx_out_enable,
  output logic                      tx_out_enable
);

  localparam int FW = 2 + N_OTHER;
  localparam int SW = FW + 5;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  if (N_OTHER < 1 || N_OTHER > 24)
  begin : g_chk_other
    $error("N_OTHER must lie between 1 and 24");
  end

  if (INIT_CYC < 2 || INIT_CYC > `MMS_INIT_CYC)
  begin : g_chk_init
    $error("INIT_CYC must lie between 2 and the management init interval");
  end

  // Fast mode limits cap what may be advertised
  if (ADV_OFF_MS > `MMS_FAST_OFF_MS || ADV_ON_MS > `MMS_FAST_ON_MS)
  begin : g_chk_adv
    $error("Advertised turn-off or turn-on limit above the fast mode cap");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_s;

  assign pin_raw = {sda_in, scl_in, second_channel_tx_fault, tx_sig_lost_in,
                    reset_input_low, other_cond_in, tx_fault_in, rx_los_in};

  // Idle-high pins reset high so no false edge appears at release
  localparam logic [SW-1:0] SYNC_RST = {2'b11, 2'b00, 1'b1, {FW{1'b0}}};

  mms_sync #(
    .W       (SW),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .pin_in   (pin_raw),
    .sync_out (pin_s)
  );

  wire [FW-1:0] cond_s   = pin_s[FW-1:0];
  wire          rstl_s   = pin_s[FW];
  wire          txlost_s = pin_s[FW+1];
  wire          tx2f_s   = pin_s[FW+2];
  wire          scl_s    = pin_s[FW+3];
  wire          sda_s    = pin_s[FW+4];

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin qualification

  localparam int RCW = $clog2(`MMS_RST_MIN_CYC + 1);
  localparam logic [RCW-1:0] RST_MIN = RCW'(`MMS_RST_MIN_CYC);

  logic [RCW-1:0] rstl_cnt_q;
  logic [RCW-1:0] rstl_cnt_d;

  // Glitches shorter than the least pulse never reset the module
  wire rst_held = (rstl_cnt_q == RST_MIN);

  assign rstl_cnt_d = rstl_s   ? '0 :
                      rst_held ? rstl_cnt_q :
                      rstl_cnt_q + RCW'(1);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rstl_cnt_q <= '0;
    else
      rstl_cnt_q <= rstl_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management init sequencing

  mms_pkg::mms_init_t init_q;
  mms_pkg::mms_init_t init_d;
  logic [31:0]        init_cnt_q;
  logic [31:0]        init_cnt_d;

  wire init_done = (init_cnt_q == INIT_CYC - 1);

  always_comb
  begin
    init_d     = init_q;
    init_cnt_d = init_cnt_q;
    case (init_q)
      mms_pkg::MMS_INIT_WAIT:
      begin
        init_cnt_d = init_cnt_q + 32'h1;
        if (rst_held)
        begin
          init_d     = mms_pkg::MMS_INIT_HOLD;
          init_cnt_d = 32'h0;
        end
        else if (init_done)
          init_d = mms_pkg::MMS_INIT_READY;
      end
      mms_pkg::MMS_INIT_HOLD:
      begin
        init_cnt_d = 32'h0;
        // Interval restarts at the rising edge of the reset pin
        if (rstl_s)
          init_d = mms_pkg::MMS_INIT_WAIT;
      end
      mms_pkg::MMS_INIT_READY:
      begin
        init_cnt_d = 32'h0;
        if (rst_held)
          init_d = mms_pkg::MMS_INIT_HOLD;
      end
      default:
      begin
        init_d     = mms_pkg::MMS_INIT_WAIT;
        init_cnt_d = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      init_q     <= mms_pkg::MMS_INIT_WAIT;
      init_cnt_q <= 32'h0;
    end
    else
    begin
      init_q     <= init_d;
      init_cnt_q <= init_cnt_d;
    end
  end

  wire soft_rst = (init_q == mms_pkg::MMS_INIT_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire bus observation

  logic scl_p_q;
  logic sda_p_q;
  logic host_seen_q;

  // Start: data falls while clock stays high
  wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_p_q     <= 1'b1;
      sda_p_q     <= 1'b1;
      host_seen_q <= 1'b0;
    end
    else
    begin
      scl_p_q     <= scl_s;
      sda_p_q     <= sda_s;
      host_seen_q <= ~soft_rst & (host_seen_q | (start_det & mgmt_ready));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  logic ack_q;
  wire  req     = avs_read | avs_write;
  wire  rd_cap  = avs_read & ~ack_q;
  wire  rd_acc  = avs_read & ack_q;
  wire  wr_acc  = avs_write & ack_q;

  // One wait cycle per access so read data can come from a flop
  assign avs_waitrequest = req & ~ack_q;

  wire sel_ctrl  = (avs_address == `MMS_REG_CTRL);
  wire sel_flags = (avs_address == `MMS_REG_FLAGS);
  wire sel_mask  = (avs_address == `MMS_REG_MASK);
  wire sel_stat  = (avs_address == `MMS_REG_STATUS);
  wire sel_adv   = (avs_address == `MMS_REG_ADV);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and mask registers

  logic [`MMS_CTRL_W-1:0] ctrl_q;
  logic [FW-1:0]          mask_q;

  wire [`MMS_CTRL_W-1:0] ctrl_wr = avs_writedata[`MMS_CTRL_W-1:0];

  // Squelch-disable is not supported and always reads zero
  wire [`MMS_CTRL_W-1:0] ctrl_wr_ok = ctrl_wr & ~(`MMS_CTRL_W'(1) << `MMS_CTRL_SQDIS);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= `MMS_CTRL_RST;
      mask_q <= '0;
    end
    else if (soft_rst)
    begin
      ctrl_q <= `MMS_CTRL_RST;
      mask_q <= '0;
    end
    else
    begin
      if (wr_acc & sel_ctrl)
        ctrl_q <= ctrl_wr_ok;
      if (wr_acc & sel_mask)
        mask_q <= avs_writedata[FW-1:0];
    end
  end

  wire txdis  = ctrl_q[`MMS_CTRL_TXDIS];
  wire rxdis  = ctrl_q[`MMS_CTRL_RXDIS];
  wire intsel = ctrl_q[`MMS_CTRL_INTSEL];

  ////////////////////////////////////////////////////////////////////////////
  // Latched flags

  logic [FW-1:0] flag_q;
  logic [FW-1:0] cond_p_q;
  logic [FW-1:0] rd_flags_q;

  // Flags latch on the onset of a condition
  wire [FW-1:0] flag_set = cond_s & ~cond_p_q;

  // Only flags already reported by this read are cleared
  wire [FW-1:0] flag_clr = (rd_acc & sel_flags) ? rd_flags_q : '0;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      flag_q   <= '0;
      cond_p_q <= '0;
    end
    else if (soft_rst)
    begin
      flag_q   <= '0;
      cond_p_q <= cond_s;
    end
    else
    begin
      flag_q   <= (flag_q & ~flag_clr) | flag_set;
      cond_p_q <= cond_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin

  logic interrupt_out_low_q;

  wire int_any = |(flag_q & ~mask_q);

  // Alternate use carries the second channel fault level
  wire interrupt_out_low_d = intsel ? tx2f_s : ~int_any;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      interrupt_out_low_q <= 1'b1;
    else
      interrupt_out_low_q <= interrupt_out_low_d;
  end

  assign interrupt_out_low = interrupt_out_low_q;

  ////////////////////////////////////////////////////////////////////////////
  // Squelch and output disables

  logic rx_en_q;
  logic tx_en_q;

  // Squelch is always active, independent of any control bit
  wire rx_sq = cond_s[`MMS_FLAG_LOS];
  wire tx_sq = txlost_s;

  // Both normal and fast mode act within a few cycles
  wire rx_en_d = ~rx_sq & ~rxdis;
  wire tx_en_d = ~tx_sq & ~txdis;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end
    else
    begin
      rx_en_q <= rx_en_d;
      tx_en_q <= tx_en_d;
    end
  end

  assign rx_out_enable = rx_en_q;
  assign tx_out_enable = tx_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  logic ready_q;
  logic mrst_q;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ready_q <= 1'b0;
      mrst_q  <= 1'b0;
    end
    else
    begin
      ready_q <= (init_d == mms_pkg::MMS_INIT_READY);
      mrst_q  <= (init_d == mms_pkg::MMS_INIT_HOLD);
    end
  end

  assign mgmt_ready   = ready_q;
  assign module_reset = mrst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  wire [`MMS_ST_W-1:0] status_v = {cond_s[`MMS_FLAG_TXF], cond_s[`MMS_FLAG_LOS], mrst_q,
                                   tx_sq, rx_sq, host_seen_q, ready_q};

  wire [15:0] adv_v = {ADV_ON_MS, ADV_OFF_MS};

  wire [31:0] rd_mux = sel_ctrl  ? 32'(ctrl_q)   :
                       sel_flags ? 32'(flag_q)   :
                       sel_mask  ? 32'(mask_q)   :
                       sel_stat  ? 32'(status_v) :
                       sel_adv   ? 32'(adv_v)    :
                       32'h0;

  logic [31:0] rdata_q;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q    <= 32'h0;
      rd_flags_q <= '0;
    end
    else if (rd_cap)
    begin
      rdata_q    <= rd_mux;
      rd_flags_q <= flag_q;
    end
  end

  assign avs_readdata = rdata_q;

endmodule

/* testbench.sv */
// Bench for the management status and timing block
`timescale 1ns/1ps
`include "mms_defs.svh"

module testbench;
  localparam int N_OTHER  = 2;
  localparam int INIT_CYC = 50;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  cond = 4'h0;
  logic        tx_lost = 1'b0;
  logic        fault2 = 1'b0;
  logic        pin_rst, scl, sda, irq_n, rdy, mod_rst, rx_en, tx_en;
  int          miscompares = 0;
  int          comparisons = 0;

  always #5 clk_sys = ~clk_sys;

  mms_host_model i_host (.clk_sys(clk_sys), .scl(scl), .sda(sda), .reset_input_low(pin_rst));

  mms_top #(.N_OTHER(N_OTHER), .INIT_CYC(INIT_CYC)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reset_input_low(pin_rst), .rx_los_in(cond[0]),
    .tx_fault_in(cond[1]), .tx_sig_lost_in(tx_lost), .other_cond_in(cond[3:2]),
    .second_channel_tx_fault(fault2), .scl_in(scl), .sda_in(sda),
    .interrupt_out_low(irq_n), .mgmt_ready(rdy), .module_reset(mod_rst),
    .rx_out_enable(rx_en), .tx_out_enable(tx_en));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic pin(input string nm, input logic v, input logic e);
    chk(nm, {31'h0, v}, {31'h0, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask

  task automatic ready_wait;
    for (int n = 0; n < INIT_CYC + 20 && rdy !== 1'b1; n++)
      @(posedge clk_sys);
    pin("ready", rdy, 1'b1);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(30000);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    tick(5);
    nrst <= 1'b1;
    ready_wait();
    rd(`MMS_REG_ADV, 32'h0000_0a03, "adv");
    rd(5'h14, 32'h0, "unmapped");
    i_host.frame(8'ha0);
    rd(`MMS_REG_STATUS, 32'h0000_0003, "status");
    $display("test init done");
    for (int i = 0; i < 4; i++)
    begin
      cond <= 4'(1 << i);
      tick(6);
      pin("irq", irq_n, 1'b0);
      pin("rx_en", rx_en, i != 0);
      rd(`MMS_REG_FLAGS, 32'(1 << i), "flags");
      tick(2);
      pin("irq", irq_n, 1'b1);
      cond <= 4'h0;
      tick(4);
    end
    cond <= 4'h9;
    tick(6);
    wr(`MMS_REG_MASK, 32'h1);
    tick(2);
    pin("irq", irq_n, 1'b0);
    wr(`MMS_REG_MASK, 32'hf);
    tick(2);
    pin("irq", irq_n, 1'b1);
    wr(`MMS_REG_MASK, 32'h0);
    tick(2);
    pin("irq", irq_n, 1'b0);
    rd(`MMS_REG_FLAGS, 32'h9, "flags");
    cond <= 4'h0;
    tick(2);
    pin("irq", irq_n, 1'b1);
    $display("test flags done");
    wr(`MMS_REG_CTRL, 32'h1);
    tick(2);
    pin("tx_en", tx_en, 1'b0);
    wr(`MMS_REG_CTRL, 32'h6);
    tick(2);
    pin("tx_en", tx_en, 1'b1);
    pin("rx_en", rx_en, 1'b0);
    wr(`MMS_REG_CTRL, 32'h5);
    tick(2);
    pin("tx_en", tx_en, 1'b0);
    wr(`MMS_REG_CTRL, 32'h8);
    tick(2);
    pin("tx_en", tx_en, 1'b1);
    pin("rx_en", rx_en, 1'b1);
    rd(`MMS_REG_CTRL, 32'h0, "ctrl");
    tx_lost <= 1'b1;
    tick(5);
    pin("tx_en", tx_en, 1'b0);
    tx_lost <= 1'b0;
    tick(5);
    pin("tx_en", tx_en, 1'b1);
    $display("test control done");
    wr(`MMS_REG_CTRL, 32'h10);
    fault2 <= 1'b1;
    tick(5);
    pin("irq", irq_n, 1'b1);
    fault2 <= 1'b0;
    tick(5);
    pin("irq", irq_n, 1'b0);
    wr(`MMS_REG_CTRL, 32'h1);
    $display("test select done");
    i_host.reset_pulse(990);
    tick(5);
    pin("mod_rst", mod_rst, 1'b0);
    fork
      i_host.reset_pulse(1010);
      begin
        tick(1009);
        pin("mod_rst", mod_rst, 1'b1);
      end
    join
    tick(5);
    pin("mod_rst", mod_rst, 1'b0);
    ready_wait();
    rd(`MMS_REG_CTRL, 32'h0, "ctrl");
    pin("tx_en", tx_en, 1'b1);
    $display("test reset done");
    tally_and_finish();
  end
endmodule

bind mms_top mms_monitor #(.N_OTHER(N_OTHER), .INIT_CYC(INIT_CYC)) i_mon (
  .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .reset_input_low(reset_input_low), .rx_los_in(rx_los_in), .tx_fault_in(tx_fault_in),
  .tx_sig_lost_in(tx_sig_lost_in), .other_cond_in(other_cond_in),
  .interrupt_out_low(interrupt_out_low), .mgmt_ready(mgmt_ready),
  .module_reset(module_reset), .rx_out_enable(rx_out_enable), .tx_out_enable(tx_out_enable));
